// ==== common/fcu_defs.vh ====
// Constants of the frequency converter unit binary config slave
`ifndef FCU_DEFS_VH
`define FCU_DEFS_VH
`define FCU_WORD_BITS      32
`define FCU_SEQ_WORDS      4
`define FCU_CMD_NOP        7'h00
`define FCU_CMD_IF_CFG     7'h01
`define FCU_CMD_BB_CFG     7'h02
`define FCU_CMD_PATH       7'h03
`define FCU_CMD_HW_CTRL    7'h04
`define FCU_CMD_HW_STAT    7'h05
`define FCU_CMD_CONV       7'h10
`define FCU_CMD_SYN        7'h11
`define FCU_CMD_BBF        7'h12
`define FCU_OP_BIT         7
`define FCU_EN_HI          23
`define FCU_EN_LO          21
`define FCU_SW_BIT         18
`define FCU_HWID_RESET     8'hFF
`define FCU_HWID_TRIG      8'h06
`define FCU_RESET_KEY      16'hA57B
`define FCU_HW_ENTRIES     16
`define FCU_ATTN_RST       6'h00
`define FCU_GAIN_RST       6'h00
`endif

// ==== rtl/fcu_spi_slave.v ====
// SPI binary command interpreter of the frequency converter unit
// Function
// - A sequence is four 32-bit words, 128 bits, counted by both ends.
// - No chaining of units; the response slot does not depend on stack position.
// - Write response is shifted out in the very next word.
// - Read response with data is shifted out in the very next word.
// - Command byte in bits 31..24, data or arguments in 23..0.
// - Command bit 7 is read flag, low bits are command id.
// - Response bit 7 is error flag, id echoed, read data in 23..0.
// - Three data bytes follow the command byte, most significant first.
// - Narrow values sit right-justified in the data word.
// - Decode ids 00-05 and 10-12.
// - No-op changes nothing and only releases the pending response.
// - IF config enables 001 receive, 010 transmit, 100 switch groups.
// - Bit 18 sets duplex switch, 0 receive 1 transmit; 20..19 reserved.
// - IF attenuations six bits each at 17..12, 11..6, 5..0.
// - Baseband config enables 001 gains, 100 switch; 17..12 reserved.
// - Baseband gains six bits each at 11..6 and 5..0, coded 26 minus gain.
// - Path select bit 0 picks receive or transmit path.
// - Hardware control write: id 23..16, value 15..0, on active path.
// - Hardware control read takes id in 23..16 and answers next word.
// - Control id FF with value A57B resets the unit to defaults.
// - With trigger enable set, new TDD values wait for the trigger.

`include "fcu_defs.vh"

module fcu_spi_slave #(
  parameter HW_ENTRIES = `FCU_HW_ENTRIES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        sck,
  input  wire        cs_n,
  input  wire        mosi,
  input  wire        external_trigger_enables,
  output reg         miso_q,
  output reg         miso_oe_n_q,
  output reg         duplex_switch_position_q,
  output reg  [5:0]  transmit_if_attenuation_q,
  output reg  [5:0]  receive_if_attenuation_a_q,
  output reg  [5:0]  receive_if_attenuation_b_q,
  output reg  [5:0]  rx_gain_a_q,
  output reg  [5:0]  rx_gain_b_q,
  output reg         active_path_q,
  output reg         hw_write_stb_q,
  output reg  [7:0]  hw_write_id_q,
  output reg  [15:0] hw_write_value_q,
  output reg  [1:0]  external_trigger_enables_q
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire sck_s;
  wire cs_sel_s;
  wire mosi_s;
  wire trig_s;

  // Select goes through inverted so that reset reads as deselected
  fcu_sync u_sck  (.clk(clk), .rstn(rstn), .din(sck),      .dout(sck_s));
  fcu_sync u_cs   (.clk(clk), .rstn(rstn), .din(~cs_n),    .dout(cs_sel_s));
  fcu_sync u_mosi (.clk(clk), .rstn(rstn), .din(mosi),     .dout(mosi_s));
  fcu_sync u_trig (.clk(clk), .rstn(rstn), .din(external_trigger_enables), .dout(trig_s));

  wire cs_n_s = ~cs_sel_s;

  reg sck_prev_q;
  reg trig_prev_q;
  reg cs_prev_q;

  // Previous levels reset to each pin's idle level, so no edge follows reset
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire trig_rise = trig_s & ~trig_prev_q;
  wire cs_start = ~cs_n_s & cs_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function known_id;
    input [6:0] id;
    begin
      case (id)
        `FCU_CMD_NOP, `FCU_CMD_IF_CFG, `FCU_CMD_BB_CFG, `FCU_CMD_PATH,
        `FCU_CMD_HW_CTRL, `FCU_CMD_HW_STAT, `FCU_CMD_CONV, `FCU_CMD_SYN,
        `FCU_CMD_BBF: known_id = 1'b1;
        default:      known_id = 1'b0;
      endcase
    end
  endfunction

  function [3:0] hw_index;
    input [7:0] id;
    begin
      hw_index = id[3:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shift engine

  reg [4:0]  bit_cnt_q;
  reg [1:0]  word_cnt_q;
  reg [31:0] rx_sh_q;
  reg [31:0] tx_sh_q;
  reg [31:0] resp_q;
  reg        word_done_q;
  reg [31:0] word_q;

  // Shadowed TDD values waiting for the trigger
  reg        pend_sw_q;
  reg        pend_sw_v_q;
  reg [5:0]  pend_tx_q;
  reg [5:0]  pend_ra_q;
  reg [5:0]  pend_rb_q;
  reg        pend_if_v_q;
  reg        pend_rxatt_q;
  reg        pend_txatt_q;
  reg [5:0]  pend_ga_q;
  reg [5:0]  pend_gb_q;
  reg        pend_bb_v_q;

  // Per-path hardware control table
  reg [15:0] hw_tab_q [0:2*HW_ENTRIES-1];

  // Control ids alias on their low four bits, one table half per path
  wire [6:0]  cmd_id   = word_q[30:24];
  wire        cmd_rd   = word_q[`FCU_OP_BIT + 24];
  wire [2:0]  cmd_en   = word_q[`FCU_EN_HI:`FCU_EN_LO];
  wire [7:0]  hw_id    = word_q[23:16];
  wire [15:0] hw_val   = word_q[15:0];
  wire [4:0]  hw_slot  = {active_path_q, hw_index(hw_id)};
  wire        unit_rst = !cmd_rd && cmd_id == `FCU_CMD_HW_CTRL &&
                         hw_id == `FCU_HWID_RESET && hw_val == `FCU_RESET_KEY;

  // Unmapped ids read back as zero data
  reg [23:0] rd_data;
  always @* begin
    rd_data = 24'h000000;
    case (cmd_id)
      `FCU_CMD_IF_CFG:  rd_data = {5'h00, duplex_switch_position_q, transmit_if_attenuation_q,
                                   receive_if_attenuation_b_q, receive_if_attenuation_a_q};
      `FCU_CMD_BB_CFG:  rd_data = {5'h00, duplex_switch_position_q, 6'h00, rx_gain_b_q, rx_gain_a_q};
      `FCU_CMD_PATH:    rd_data = {23'h000000, active_path_q};
      `FCU_CMD_HW_CTRL: rd_data = {hw_id, hw_id == `FCU_HWID_TRIG ?
                                   {14'h0000, external_trigger_enables_q} : hw_tab_q[hw_slot]};
      default:          rd_data = 24'h000000;
    endcase
  end

  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      bit_cnt_q <= 5'h00;
      word_cnt_q <= 2'h0;
      rx_sh_q <= 32'h00000000;
      tx_sh_q <= 32'h00000000;
      resp_q <= 32'h00000000;
      word_done_q <= 1'b0;
      word_q <= 32'h00000000;
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      trig_prev_q <= trig_s;
      cs_prev_q <= cs_n_s;
      word_done_q <= 1'b0;
      miso_oe_n_q <= cs_n_s;
      if (cs_n_s) begin
        // Frame lost: realign at next select
        // A cut word is dropped; the pending answer goes out again
        bit_cnt_q <= 5'h00;
        word_cnt_q <= 2'h0;
      end else begin
        if (cs_start) begin
          tx_sh_q <= resp_q;
          miso_q <= resp_q[31];
        end
        // Mode 0: sample on the rising link edge, shift on the falling one
        if (sck_rise) begin
          rx_sh_q <= {rx_sh_q[30:0], mosi_s};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == 5'h1F) begin
            word_q <= {rx_sh_q[30:0], mosi_s};
            word_done_q <= 1'b1;
            word_cnt_q <= word_cnt_q + 2'h1;
          end
        end
        if (sck_fall) begin
          if (bit_cnt_q == 5'h00) begin
            // Word boundary: load answer to the previous command
            tx_sh_q <= resp_q;
            miso_q <= resp_q[31];
          end else begin
            tx_sh_q <= {tx_sh_q[30:0], 1'b0};
            miso_q <= tx_sh_q[30];
          end
        end
      end
      if (word_done_q) begin
        // No slot positioning across chained units: the answer always goes out in the next word
        resp_q <= {known_id(cmd_id) ? 1'b0 : 1'b1, cmd_id,
                   cmd_rd ? rd_data : 24'h000000};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command execution

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      duplex_switch_position_q <= 1'b0;
      transmit_if_attenuation_q <= `FCU_ATTN_RST;
      receive_if_attenuation_a_q <= `FCU_ATTN_RST;
      receive_if_attenuation_b_q <= `FCU_ATTN_RST;
      rx_gain_a_q <= `FCU_GAIN_RST;
      rx_gain_b_q <= `FCU_GAIN_RST;
      active_path_q <= 1'b0;
      hw_write_stb_q <= 1'b0;
      hw_write_id_q <= 8'h00;
      hw_write_value_q <= 16'h0000;
      external_trigger_enables_q <= 2'h0;
      pend_sw_q <= 1'b0;
      pend_sw_v_q <= 1'b0;
      pend_tx_q <= 6'h00;
      pend_ra_q <= 6'h00;
      pend_rb_q <= 6'h00;
      pend_if_v_q <= 1'b0;
      pend_rxatt_q <= 1'b0;
      pend_txatt_q <= 1'b0;
      pend_ga_q <= 6'h00;
      pend_gb_q <= 6'h00;
      pend_bb_v_q <= 1'b0;
      for (i = 0; i < 2*HW_ENTRIES; i = i + 1) begin
        hw_tab_q[i] <= 16'h0000;
      end
    end else begin
      hw_write_stb_q <= 1'b0;
      if (trig_rise) begin
        // Trigger applies the held values
        if (pend_sw_v_q) begin
          duplex_switch_position_q <= pend_sw_q;
        end
        if (pend_if_v_q && pend_rxatt_q) begin
          receive_if_attenuation_a_q <= pend_ra_q;
          receive_if_attenuation_b_q <= pend_rb_q;
        end
        if (pend_if_v_q && pend_txatt_q) begin
          transmit_if_attenuation_q <= pend_tx_q;
        end
        if (pend_bb_v_q) begin
          rx_gain_a_q <= pend_ga_q;
          rx_gain_b_q <= pend_gb_q;
        end
        pend_sw_v_q <= 1'b0;
        pend_if_v_q <= 1'b0;
        pend_bb_v_q <= 1'b0;
      end
      if (word_done_q && !cmd_rd) begin
        case (cmd_id)
          `FCU_CMD_IF_CFG, `FCU_CMD_BB_CFG: begin
            if (cmd_en[2]) begin
              if (external_trigger_enables_q[1]) begin
                pend_sw_q <= word_q[`FCU_SW_BIT];
                pend_sw_v_q <= 1'b1;
              end else begin
                duplex_switch_position_q <= word_q[`FCU_SW_BIT];
              end
            end
            if (cmd_id == `FCU_CMD_IF_CFG && (cmd_en[0] || cmd_en[1])) begin
              if (external_trigger_enables_q[0]) begin
                pend_tx_q <= word_q[17:12];
                pend_rb_q <= word_q[11:6];
                pend_ra_q <= word_q[5:0];
                pend_txatt_q <= cmd_en[1];
                pend_rxatt_q <= cmd_en[0];
                pend_if_v_q <= 1'b1;
              end else begin
                if (cmd_en[1]) begin
                  transmit_if_attenuation_q <= word_q[17:12];
                end
                if (cmd_en[0]) begin
                  receive_if_attenuation_b_q <= word_q[11:6];
                  receive_if_attenuation_a_q <= word_q[5:0];
                end
              end
            end
            if (cmd_id == `FCU_CMD_BB_CFG && cmd_en[0]) begin
              if (external_trigger_enables_q[0]) begin
                pend_gb_q <= word_q[11:6];
                pend_ga_q <= word_q[5:0];
                pend_bb_v_q <= 1'b1;
              end else begin
                rx_gain_b_q <= word_q[11:6];
                rx_gain_a_q <= word_q[5:0];
              end
            end
          end
          `FCU_CMD_PATH: begin
            active_path_q <= word_q[0];
          end
          `FCU_CMD_HW_CTRL: begin
            hw_write_stb_q <= 1'b1;
            hw_write_id_q <= hw_id;
            hw_write_value_q <= hw_val;
            if (hw_id == `FCU_HWID_TRIG) begin
              external_trigger_enables_q <= hw_val[1:0];
            end else begin
              hw_tab_q[hw_slot] <= hw_val;
            end
            if (unit_rst) begin
              // Defaults restored; the response still follows
              // Control table is kept across the unit reset
              duplex_switch_position_q <= 1'b0;
              transmit_if_attenuation_q <= `FCU_ATTN_RST;
              receive_if_attenuation_a_q <= `FCU_ATTN_RST;
              receive_if_attenuation_b_q <= `FCU_ATTN_RST;
              rx_gain_a_q <= `FCU_GAIN_RST;
              rx_gain_b_q <= `FCU_GAIN_RST;
              active_path_q <= 1'b0;
              external_trigger_enables_q <= 2'h0;
              pend_sw_v_q <= 1'b0;
              pend_if_v_q <= 1'b0;
              pend_bb_v_q <= 1'b0;
            end
          end
          default: begin
            // No-op and unknown ids leave state alone
          end
        endcase
      end
    end
  end

endmodule

// ==== rtl/fcu_sync.v ====
// Three-stage input synchroniser with agreement filter
module fcu_sync (
  input  wire clk,
  input  wire rstn,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts only once the last two stages agree
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// ==== verification/fcu_spi_master.sv ====
// SPI master model: mode 0 frames at a 64 ns link period
module fcu_spi_master (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // A count below 128 that is not a multiple of 32 aborts the frame mid-word
  task automatic frame(input logic [127:0] tx, input int nbits, output logic [127:0] rx);
    int i;
    rx = 128'h0;
    cs_n = 1'b0;
    #32;
    for (i = 0; i < nbits; i++) begin
      mosi = tx[127 - i];
      #32 sck = 1'b1;
      rx[127 - i] = miso;
      #32 sck = 1'b0;
    end
    #64 cs_n = 1'b1;
    mosi = ~mosi;
    #64;
  endtask
endmodule

// ==== verification/fcu_spi_slave_checker.sv ====
// Port-level concurrent checks of the binary config slave
module fcu_spi_slave_checker #(
  parameter HW_ENTRIES = 16
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        mosi,
  input wire logic        external_trigger_enables,
  input wire logic        miso_q,
  input wire logic        miso_oe_n_q,
  input wire logic        duplex_switch_position_q,
  input wire logic [5:0]  transmit_if_attenuation_q,
  input wire logic [5:0]  receive_if_attenuation_a_q,
  input wire logic [5:0]  receive_if_attenuation_b_q,
  input wire logic [5:0]  rx_gain_a_q,
  input wire logic [5:0]  rx_gain_b_q,
  input wire logic        active_path_q,
  input wire logic        hw_write_stb_q,
  input wire logic [7:0]  hw_write_id_q,
  input wire logic [15:0] hw_write_value_q,
  input wire logic [1:0]  external_trigger_enables_q
);
  wire [29:0] levels = {transmit_if_attenuation_q, receive_if_attenuation_a_q, receive_if_attenuation_b_q,
                        rx_gain_a_q, rx_gain_b_q};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  AST_RST_VALUES: assert property (!$past(rstn) |-> miso_oe_n_q && !duplex_switch_position_q
    && !active_path_q && !hw_write_stb_q && levels == 30'h0 && external_trigger_enables_q == 2'h0)
    else $error("outputs not at reset values");
  AST_OE_IDLE: assert property (cs_n [*8] |-> miso_oe_n_q)
    else $error("serial output driven while deselected");
  AST_OE_DRIVE: assert property (!cs_n [*8] |-> !miso_oe_n_q)
    else $error("serial output idle while selected");
  // Sync lag puts every shift well before the next rising link edge
  AST_MISO_HOLD: assert property ((sck && !cs_n) [*2] |-> $stable(miso_q))
    else $error("serial output moved while link clock high");
  AST_IDLE_STABLE: assert property ((cs_n && !external_trigger_enables) [*8] |=>
    $stable({duplex_switch_position_q, levels, active_path_q}))
    else $error("settings moved outside a frame");
  AST_STB_PULSE: assert property (hw_write_stb_q |=> !hw_write_stb_q [*8])
    else $error("control strobe longer than one cycle");
  AST_TRIG_HOLD: assert property ((external_trigger_enables_q[0] && !external_trigger_enables) [*8]
    ##1 external_trigger_enables_q[0] |-> $stable(levels))
    else $error("level settings moved without trigger");
  AST_PATH_IN_FRAME: assert property ($changed(active_path_q) |-> !$past(cs_n, 3))
    else $error("active path moved outside a frame");
endmodule

bind fcu_spi_slave fcu_spi_slave_checker #(.HW_ENTRIES(HW_ENTRIES)) i_fcu_spi_slave_checker (
  .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .mosi(mosi), .external_trigger_enables(external_trigger_enables), .miso_q(miso_q),
  .miso_oe_n_q(miso_oe_n_q), .duplex_switch_position_q(duplex_switch_position_q),
  .transmit_if_attenuation_q(transmit_if_attenuation_q), .receive_if_attenuation_a_q(receive_if_attenuation_a_q),
  .receive_if_attenuation_b_q(receive_if_attenuation_b_q), .rx_gain_a_q(rx_gain_a_q), .rx_gain_b_q(rx_gain_b_q),
  .active_path_q(active_path_q), .hw_write_stb_q(hw_write_stb_q), .hw_write_id_q(hw_write_id_q),
  .hw_write_value_q(hw_write_value_q), .external_trigger_enables_q(external_trigger_enables_q)
);

// ==== verification/fcu_spi_slave_test.sv ====
// Self-checking bench of the binary config slave
`include "fcu_defs.vh"
module fcu_spi_slave_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] resp;
    logic [31:0] msk;
    logic [31:0] st;
  } fcu_row_t;
  logic         clk;
  logic         rstn = 1'b0;
  logic         external_trigger_enables = 1'b0;
  wire          sck, cs_n, mosi, miso_q, miso_oe_n_q, sw, path, stb;
  wire  [5:0]   tx_at, rx_a, rx_b, g_a, g_b;
  wire  [7:0]   h_id;
  wire  [15:0]  h_val;
  wire  [1:0]   tr_en;
  // Released line shows the inverse rather than a stale level
  wire          miso_line = miso_oe_n_q ? ~miso_q : miso_q;
  wire  [31:0]  st = {sw, tx_at, rx_a, rx_b, g_a, g_b, path};
  int           failures = 0;
  int           cmp_count = 0;
  int           stb_count = 0;
  logic [127:0] rx;
  fcu_row_t     rows[$];
  logic [6:0]   codes[5] = '{`FCU_CMD_HW_STAT, `FCU_CMD_CONV, `FCU_CMD_SYN, `FCU_CMD_BBF, 7'h13};
  fcu_spi_slave i_fcu_spi_slave (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .external_trigger_enables(external_trigger_enables), .miso_q(miso_q), .miso_oe_n_q(miso_oe_n_q), .duplex_switch_position_q(sw),
    .transmit_if_attenuation_q(tx_at), .receive_if_attenuation_a_q(rx_a), .receive_if_attenuation_b_q(rx_b),
    .rx_gain_a_q(g_a), .rx_gain_b_q(g_b), .active_path_q(path), .hw_write_stb_q(stb), .hw_write_id_q(h_id),
    .hw_write_value_q(h_val), .external_trigger_enables_q(tr_en));
  fcu_spi_master i_fcu_spi_master (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (stb === 1'b1) stb_count++;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got, input logic [31:0] msk);
    cmp_count++;
    if ((got & msk) !== (exp & msk)) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp & msk, got & msk);
    end
  endtask
  task automatic send(input logic [31:0] c0, input logic [31:0] c1);
    i_fcu_spi_master.frame({c0, c1, 64'h0}, 128, rx);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (12) @(posedge clk);
    check("reset outputs", 32'h0, st, 32'hFFFFFFFF);
    send(32'h0, 32'h0);
    rows.push_back('{32'h01E6D54A, 32'h01000000, 32'hFF000000, {1'b1, 6'h2D, 6'h0A, 6'h15, 12'h0, 1'b0}});
    rows.push_back('{32'h01200FFF, 32'h01000000, 32'hFF000000, {1'b1, 6'h2D, 6'h3F, 6'h3F, 12'h0, 1'b0}});
    rows.push_back('{32'h0143F000, 32'h01000000, 32'hFF000000, {1'b1, 6'h3F, 6'h3F, 6'h3F, 12'h0, 1'b0}});
    rows.push_back('{32'h01800000, 32'h01000000, 32'hFF000000, {1'b0, 6'h3F, 6'h3F, 6'h3F, 12'h0, 1'b0}});
    rows.push_back('{32'h0223F8C0, 32'h02000000, 32'hFF000000, {1'b0, 18'h3FFFF, 6'h00, 6'h23, 1'b0}});
    rows.push_back('{32'h02840000, 32'h02000000, 32'hFF000000, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b0}});
    rows.push_back('{32'h03000001, 32'h03000000, 32'hFF000000, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h011C0FFF, 32'h01000000, 32'hFF000000, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h81000000, 32'h0107FFFF, 32'hFFFFFFFF, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h82000000, 32'h020408C0, 32'hFFFFFFFF, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h83000000, 32'h03000001, 32'hFFFFFFFF, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h04031234, 32'h04000000, 32'hFF000000, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h84030000, 32'h04001234, 32'hFF00FFFF, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h07000000, 32'h87000000, 32'hFF000000, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    rows.push_back('{32'h00000000, 32'h00000000, 32'hFF000000, {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    foreach (codes[i])
      rows.push_back('{{1'b1, codes[i], 24'h0}, {codes[i] == 7'h13, codes[i], 24'h0}, 32'hFFFFFFFF,
                       {1'b1, 18'h3FFFF, 6'h00, 6'h23, 1'b1}});
    foreach (rows[i]) begin
      send(rows[i].cmd, 32'h0);
      check("response word", rows[i].resp, rx[95:64], rows[i].msk);
      check("settings", rows[i].st, st, 32'hFFFFFFFF);
    end
    $display("table rows done");
    send(32'h0405ABCD, 32'h040A0F0F);
    check("first response", 32'h04000000, rx[95:64], 32'hFF000000);
    check("second response", 32'h04000000, rx[63:32], 32'hFF000000);
    check("strobes", 32'd3, stb_count, 32'hFFFFFFFF);
    check("control write", 32'h000A0F0F, {8'h0, h_id, h_val}, 32'hFFFFFFFF);
    send(32'h840A0000, 32'h03000000);
    check("read on transmit", 32'h04000F0F, rx[95:64], 32'hFF00FFFF);
    send(32'h840A0000, 32'h0);
    check("read on receive", 32'h04000000, rx[95:64], 32'hFF00FFFF);
    $display("control tests done");
    send(32'h04060001, 32'h01200081);
    check("trigger enables", 32'h1, {30'h0, tr_en}, 32'hFFFFFFFF);
    check("held levels", {1'b1, 18'h3FFFF, 12'h023, 1'b0}, st, 32'hFFFFFFFF);
    @(posedge clk);
    #1 external_trigger_enables = 1'b1;
    repeat (4) @(posedge clk);
    #1 external_trigger_enables = 1'b0;
    repeat (10) @(posedge clk);
    check("triggered levels", {1'b1, 6'h3F, 6'h01, 6'h02, 12'h023, 1'b0}, st, 32'hFFFFFFFF);
    send(32'h04FFA57B, 32'h0);
    check("unit reset", 32'h0, st, 32'hFFFFFFFF);
    check("unit reset enables", 32'h0, {30'h0, tr_en}, 32'hFFFFFFFF);
    $display("trigger and unit reset done");
    i_fcu_spi_master.frame({32'h03000001, 96'h0}, 20, rx);
    send(32'h03000001, 32'h0);
    check("after abort", 32'h03000000, rx[95:64], 32'hFF000000);
    check("path after abort", 32'h1, st, 32'hFFFFFFFF);
    @(posedge clk);
    #1 rstn = 1'b0;
    repeat (3) @(posedge clk);
    check("async reset", 32'h0, st, 32'hFFFFFFFF);
    #1 rstn = 1'b1;
    repeat (12) @(posedge clk);
    $display("abort and reset done");
    wrap_up();
  end
endmodule
